// file: rtl/exception_priority_encoder.sv
// Core exception priority encoder with APB status registers
// Operation
// RL1 - Reset input resets the core; no particular register is written. Code reloads control and clears the rest but the debug interrupt bits.
// RL2 - Single-step ranks above everything except reset.
// RL3 - Taken single-step sets the single-step bit in debug state.
// RL4 - Debug interrupt from pin or from controller break bit.
// RL5 - Taken debug interrupt sets that virtual processor's indication bit.
// RL6 - Taken imprecise load break sets its debug indication bit.
// RL7 - Non-maskable input raises exception and sets status indication bit. Code raises it only while control bit 4 is set.
// RL8 - Root lookup machine check reports code 0x18 on root lookups.
// RL9 - Guest lookup machine check only on first-step guest lookups.
// RL10 - Machine check cause goes to root or guest granularity copy.
// RL11 - Machine check is signalled with its causing instruction.
// RL12 - Enabled root interrupt reports code 0x00, below machine check.
// RL13 - Only the highest pending exception is taken and its code kept.
// RL14 - Order: reset, step, debug interrupt, load break, NMI, check, irq.
// RL15 - All requests evaluated each cycle; one winner presented.
`timescale 1ns/1ps
`include "exc_prio_defs.svh"
module exception_priority_encoder
  import exc_prio_pkg::*;
#(
  parameter int NUM_VP = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External sources
  input wire logic sys_reset_req,
  input wire logic nmi_in,
  input wire logic debug_interrupt_request,
  input wire logic controller_break,
  input wire logic [$clog2(NUM_VP)-1:0] cur_vp,
  // Pipeline and lookup logic
  input wire logic single_step_break,
  input wire logic imprecise_load_data_break,
  input wire logic root_lookup_fault,
  input wire logic guest_lookup_fault,
  input wire logic second_step_or_root_lookup,
  input wire logic first_step_guest_lookup,
  input wire logic [`CAUSE_W-1:0] lookup_fault_cause,
  input wire logic root_interrupt,
  input wire logic root_interrupt_enabled,
  // Winner
  output logic exc_valid,
  output exc_kind_t exc_kind,
  output logic [`CODE_W-1:0] exception_code_field,
  output logic core_reset
);
  exc_kind_t kind_w;
  logic [`CODE_W-1:0] code_w;
  logic dbgint_w;
  logic root_mc_w;
  logic guest_mc_w;
  logic [NUM_VP-1:0] dbgint_bits;
  logic wr;
  logic rd;
  logic taken;
  logic step_en_w;
  logic dbgint_en_w;
  logic impr_en_w;
  logic nmi_en_w;
  logic mcheck_en_w;
  logic intr_en_w;
  logic core_reset_q;
  logic core_reset_d;

  // Register map, one word each, byte offsets from the defs header:
  //   control: bits 6:1 enable step, debug interrupt, load break,
  //     non-maskable, lookup check and interrupt; all set after reset
  //   status: bit 0 shows a taken non-maskable interrupt
  //   debug: bit 0 step, bit 1 load break, from bit 8 one debug
  //     interrupt bit per virtual processor
  //   last code: code of the latest winner other than reset
  //   root and guest grain: cause of the latest lookup check
  // Indication bits clear when written with one; a hardware set in
  // the same cycle wins over the clear. Unmapped offsets answer with
  // an error, read as zero and ignore writes.
  // Software enables for each source but reset, bit per kind
  logic [6:0] ctrl_q;
  logic [6:0] ctrl_d;
  logic step_bit_q;
  logic step_bit_d;
  logic impr_bit_q;
  logic impr_bit_d;
  logic nmi_bit_q;
  logic nmi_bit_d;
  logic [`CAUSE_W-1:0] root_grain_q;
  logic [`CAUSE_W-1:0] root_grain_d;
  logic [`CAUSE_W-1:0] guest_grain_q;
  logic [`CAUSE_W-1:0] guest_grain_d;
  logic [`CODE_W-1:0] last_code_q;
  logic [`CODE_W-1:0] last_code_d;
  logic exc_valid_q;
  logic exc_valid_d;
  exc_kind_t kind_q;
  exc_kind_t kind_d;
  logic [`CODE_W-1:0] code_q;
  logic [`CODE_W-1:0] code_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `REG_CTRL) || (a == `REG_STATUS) ||
      (a == `REG_DEBUG) || (a == `REG_LAST) ||
      (a == `REG_ROOT_GRAIN) || (a == `REG_GUEST_GRAIN);
  endfunction

  // Debug interrupt from the pin or the controller break bit (see RL4)
  assign dbgint_w = debug_interrupt_request | controller_break;
  // Lookup checks qualified by the lookup kind (see RL8, RL9)
  assign root_mc_w = root_lookup_fault & second_step_or_root_lookup;
  assign guest_mc_w = guest_lookup_fault & first_step_guest_lookup;

  // Software enables gate every source but reset
  assign step_en_w = single_step_break & ctrl_q[1];
  assign dbgint_en_w = dbgint_w & ctrl_q[2];
  assign impr_en_w = imprecise_load_data_break & ctrl_q[3];
  assign nmi_en_w = nmi_in & ctrl_q[4];
  assign mcheck_en_w = (root_mc_w | guest_mc_w) & ctrl_q[5];
  assign intr_en_w = root_interrupt & root_interrupt_enabled & ctrl_q[6];

  // Combinational ranking every cycle (see RL13, RL15)
  exc_rank u_rank (
    .reset_req(sys_reset_req),
    .step_req(step_en_w),
    .dbgint_req(dbgint_en_w),
    .impr_req(impr_en_w),
    .nmi_req(nmi_en_w),
    .mcheck_req(mcheck_en_w),
    .intr_req(intr_en_w),
    .kind(kind_w),
    .code(code_w)
  );

  assign wr = psel & penable & pwrite & pready_q;
  assign rd = psel & ~pwrite;
  assign taken = kind_w != EXC_NONE;

  vp_debug_bits #(
    .NUM_VP(NUM_VP)
  ) u_dbgint_bits (
    .pclk(pclk),
    .presetn(presetn),
    .set_en(kind_w == EXC_DBGINT), // see RL5
    .set_vp(cur_vp),
    .clr_en(wr && paddr == `REG_DEBUG),
    .clr_mask(pwdata[`BIT_DBG_INT +: NUM_VP]),
    .bits(dbgint_bits)
  );

  always_comb begin
    ctrl_d = ctrl_q;
    step_bit_d = step_bit_q;
    impr_bit_d = impr_bit_q;
    nmi_bit_d = nmi_bit_q;
    root_grain_d = root_grain_q;
    guest_grain_d = guest_grain_q;
    last_code_d = last_code_q;
    // Write one to clear indication bits; CTRL bit 0 unused
    if (wr) begin
      case (paddr)
        `REG_CTRL: ctrl_d = {pwdata[6:1], 1'b0};
        `REG_STATUS: begin
          if (pwdata[`BIT_STAT_NMI]) nmi_bit_d = 1'b0;
        end
        `REG_DEBUG: begin
          if (pwdata[`BIT_DBG_STEP]) step_bit_d = 1'b0;
          if (pwdata[`BIT_DBG_IMPR]) impr_bit_d = 1'b0;
        end
        default: ;
      endcase
    end
    // Hardware sets after software clears, so sets win
    case (kind_w)
      EXC_STEP: step_bit_d = 1'b1; // see RL3
      EXC_IMPR: impr_bit_d = 1'b1; // see RL6
      EXC_NMI: nmi_bit_d = 1'b1; // see RL7
      EXC_MCHECK: begin
        // Root copy for root checks, guest copy otherwise (see RL10)
        if (root_mc_w) begin
          root_grain_d = lookup_fault_cause;
        end else begin
          guest_grain_d = lookup_fault_cause;
        end
      end
      default: ;
    endcase
    // Reset itself records nothing (see RL1)
    if (taken && kind_w != EXC_RESET) begin
      last_code_d = code_w; // see RL13
    end
    // Reset exception clears indications and re-enables all sources;
    // the per-processor debug interrupt bits are kept
    if (sys_reset_req) begin
      ctrl_d = `CTRL_RESET; // see RL1
      step_bit_d = 1'b0;
      impr_bit_d = 1'b0;
      nmi_bit_d = 1'b0;
      root_grain_d = '0;
      guest_grain_d = '0;
      last_code_d = `CODE_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      step_bit_q <= 1'b0;
      impr_bit_q <= 1'b0;
      nmi_bit_q <= 1'b0;
      root_grain_q <= '0;
      guest_grain_q <= '0;
      last_code_q <= `CODE_NONE;
    end else begin
      ctrl_q <= ctrl_d;
      step_bit_q <= step_bit_d;
      impr_bit_q <= impr_bit_d;
      nmi_bit_q <= nmi_bit_d;
      root_grain_q <= root_grain_d;
      guest_grain_q <= guest_grain_d;
      last_code_q <= last_code_d;
    end
  end

  // Winner registered one cycle later, tied to its causing cycle (see RL11)
  always_comb begin
    exc_valid_d = taken; // see RL15
    kind_d = kind_w;
    code_d = code_w;
    core_reset_d = kind_w == EXC_RESET; // see RL1
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_valid_q <= 1'b0;
      kind_q <= EXC_NONE;
      code_q <= `CODE_NONE;
      core_reset_q <= 1'b0;
    end else begin
      exc_valid_q <= exc_valid_d;
      kind_q <= kind_d;
      code_q <= code_d;
      core_reset_q <= core_reset_d;
    end
  end

  // APB slave: no wait states, pready high in the first access cycle
  always_comb begin
    pready_d = psel & ~penable;
    pslverr_d = psel & ~penable & ~mapped(paddr);
    prdata_d = prdata_q;
    if (rd && !penable) begin
      case (paddr)
        `REG_CTRL: prdata_d = {25'h0, ctrl_q};
        `REG_STATUS: prdata_d = {31'h0, nmi_bit_q};
        `REG_DEBUG: begin
          prdata_d = '0;
          prdata_d[`BIT_DBG_STEP] = step_bit_q;
          prdata_d[`BIT_DBG_IMPR] = impr_bit_q;
          prdata_d[`BIT_DBG_INT +: NUM_VP] = dbgint_bits;
        end
        `REG_LAST: prdata_d = {27'h0, last_code_q};
        `REG_ROOT_GRAIN: prdata_d = {28'h0, root_grain_q};
        `REG_GUEST_GRAIN: prdata_d = {28'h0, guest_grain_q};
        default: prdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign exc_valid = exc_valid_q;
  assign exc_kind = kind_q;
  assign exception_code_field = code_q;
  assign core_reset = core_reset_q;
endmodule

// file: rtl/exc_prio_defs.svh
// Constants of the exception priority encoder
`ifndef EXC_PRIO_DEFS_SVH
`define EXC_PRIO_DEFS_SVH
`define CODE_W 5
`define CODE_LOOKUP_MCHECK 5'h18
`define CODE_INTERRUPT 5'h00
`define CODE_NONE 5'h1f
`define CAUSE_W 4
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_DEBUG 12'h008
`define REG_LAST 12'h00c
`define REG_ROOT_GRAIN 12'h010
`define REG_GUEST_GRAIN 12'h014
`define BIT_DBG_STEP 0
`define BIT_DBG_IMPR 1
`define BIT_DBG_INT 8
`define BIT_STAT_NMI 0
`define CTRL_RESET 7'h7e
`endif

// file: rtl/exc_prio_pkg.sv
// Types of the exception priority encoder
package exc_prio_pkg;
  typedef enum logic [2:0] {
    EXC_NONE,
    EXC_RESET,
    EXC_STEP,
    EXC_DBGINT,
    EXC_IMPR,
    EXC_NMI,
    EXC_MCHECK,
    EXC_INTR
  } exc_kind_t;
endpackage

// file: rtl/exc_rank.sv
// Fixed-priority selection of one pending exception
`timescale 1ns/1ps
`include "exc_prio_defs.svh"
module exc_rank
  import exc_prio_pkg::*;
(
  // Pending conditions
  input wire logic reset_req,
  input wire logic step_req,
  input wire logic dbgint_req,
  input wire logic impr_req,
  input wire logic nmi_req,
  input wire logic mcheck_req,
  input wire logic intr_req,
  // Winner
  output exc_kind_t kind,
  output logic [`CODE_W-1:0] code
);
  always_comb begin
    // Highest first; step above all but reset (see RL2, RL14)
    if (reset_req) begin
      kind = EXC_RESET;
    end else if (step_req) begin
      kind = EXC_STEP;
    end else if (dbgint_req) begin
      kind = EXC_DBGINT;
    end else if (impr_req) begin
      kind = EXC_IMPR;
    end else if (nmi_req) begin
      kind = EXC_NMI;
    end else if (mcheck_req) begin
      kind = EXC_MCHECK;
    end else if (intr_req) begin
      kind = EXC_INTR;
    end else begin
      kind = EXC_NONE;
    end
  end

  always_comb begin
    case (kind)
      EXC_MCHECK: code = `CODE_LOOKUP_MCHECK; // see RL8
      EXC_INTR: code = `CODE_INTERRUPT; // see RL12
      default: code = `CODE_NONE;
    endcase
  end
endmodule

// file: rtl/vp_debug_bits.sv
// Per virtual processor debug interrupt indication bits
`timescale 1ns/1ps
`include "exc_prio_defs.svh"
module vp_debug_bits #(
  parameter int NUM_VP = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic set_en,
  input wire logic [$clog2(NUM_VP)-1:0] set_vp,
  input wire logic clr_en,
  input wire logic [NUM_VP-1:0] clr_mask,
  // State
  output logic [NUM_VP-1:0] bits
);
  logic [NUM_VP-1:0] bits_q;
  logic [NUM_VP-1:0] bits_d;

  always_comb begin
    bits_d = bits_q;
    if (clr_en) begin
      bits_d = bits_q & ~clr_mask;
    end
    // One bit per virtual processor; set wins over clear (see RL5)
    if (set_en) begin
      bits_d[set_vp] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bits_q <= '0;
    end else begin
      bits_q <= bits_d;
    end
  end

  assign bits = bits_q;
endmodule

// file: bench/exc_source_model.sv
// Model of the pipeline, lookup logic and external exception sources
`timescale 1ns/1ps
module exc_source_model (
  // Selection from the bench, one bit per source
  input wire logic [9:0] req,
  // Lines towards the encoder
  output logic sys_reset_req, nmi_in, single_step_break,
  output logic debug_interrupt_request, controller_break,
  output logic imprecise_load_data_break, root_interrupt,
  output logic root_lookup_fault, second_step_or_root_lookup,
  output logic guest_lookup_fault, first_step_guest_lookup,
  output logic root_interrupt_enabled
);
  assign sys_reset_req = req[0];
  assign single_step_break = req[1];
  assign debug_interrupt_request = req[2];
  assign controller_break = req[8];
  assign imprecise_load_data_break = req[3];
  assign nmi_in = req[4];
  // Faults come only with their lookup kind, bit 9 breaks that
  assign root_lookup_fault = req[5];
  assign second_step_or_root_lookup = req[5];
  assign guest_lookup_fault = req[6] | req[9];
  assign first_step_guest_lookup = req[6];
  assign root_interrupt = req[7];
  assign root_interrupt_enabled = req[7];
endmodule

// file: bench/epe_props.sv
// Checker for the exception priority encoder
`timescale 1ns/1ps
module epe_props
  import exc_prio_pkg::*;
(
  // Clock, reset and bus handshake
  input wire logic pclk, presetn, psel, penable, pready,
  // Sources
  input wire logic sys_reset_req, nmi_in, single_step_break,
  input wire logic debug_interrupt_request, controller_break,
  input wire logic imprecise_load_data_break, root_interrupt,
  input wire logic root_lookup_fault, second_step_or_root_lookup,
  input wire logic guest_lookup_fault, first_step_guest_lookup,
  input wire logic root_interrupt_enabled,
  // Winner
  input wire logic exc_valid, core_reset,
  input wire exc_kind_t exc_kind,
  input wire logic [4:0] exception_code_field
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire r0 = sys_reset_req;
  wire h2 = r0 | single_step_break;
  wire h3 = h2 | debug_interrupt_request | controller_break;
  wire h4 = h3 | imprecise_load_data_break;
  wire h5 = h4 | nmi_in;
  wire rmc = root_lookup_fault & second_step_or_root_lookup;
  wire gmc = guest_lookup_fault & first_step_guest_lookup;
  wire irq = root_interrupt & root_interrupt_enabled;
  wire any = h5 | rmc | gmc | irq;
  a_reset_first: assert property (r0 |=> core_reset &&
    exc_kind == EXC_RESET && exception_code_field == 5'h1f)
    else $error("reset exception not taken");
  a_step_rank: assert property (single_step_break && !r0 |=>
    exc_kind == EXC_STEP) else $error("single step lost");
  a_dbgint_rank: assert property (h3 && !h2 |=>
    exc_kind == EXC_DBGINT) else $error("debug interrupt lost");
  a_impr_rank: assert property (h4 && !h3 |=>
    exc_kind == EXC_IMPR) else $error("load break lost");
  a_nmi_rank: assert property (nmi_in && !h4 |=>
    exc_kind == EXC_NMI) else $error("nmi lost");
  a_mcheck_code: assert property ((rmc || gmc) && !h5 |=>
    exc_kind == EXC_MCHECK && exception_code_field == 5'h18)
    else $error("machine check wrong");
  a_guest_gate: assert property (guest_lookup_fault &&
    !any |=> !exc_valid) else $error("guest check off lookup");
  a_intr_code: assert property (irq && !h5 && !rmc && !gmc |=>
    exc_kind == EXC_INTR && exception_code_field == 5'h00)
    else $error("interrupt wrong");
  a_valid_match: assert property (any |=> exc_valid)
    else $error("winner missing");
  a_no_spurious: assert property (!any |=> !exc_valid)
    else $error("exception without request");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  cover property (r0);
  cover property (rmc && !h5);
  cover property (irq && !h5);
endmodule
bind exception_priority_encoder epe_props u_props (.pclk, .presetn,
  .psel, .penable, .pready, .sys_reset_req, .nmi_in,
  .single_step_break, .debug_interrupt_request, .controller_break,
  .imprecise_load_data_break, .root_interrupt, .root_lookup_fault,
  .second_step_or_root_lookup, .guest_lookup_fault,
  .first_step_guest_lookup, .root_interrupt_enabled, .exc_valid,
  .core_reset, .exc_kind, .exception_code_field);

// file: bench/exception_priority_encoder_tb.sv
// Self-checking bench for the exception priority encoder
`timescale 1ns/1ps
`include "exc_prio_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module exception_priority_encoder_tb
  import exc_prio_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic err;
  logic pready, pslverr, exc_valid, core_reset;
  logic [1:0] cur_vp = 2'h2;
  logic [9:0] req = 0;
  logic [3:0] lookup_fault_cause = 4'h0;
  logic [4:0] exception_code_field;
  exc_kind_t exc_kind;
  logic sys_reset_req, nmi_in, single_step_break, debug_interrupt_request;
  logic controller_break, imprecise_load_data_break, root_interrupt;
  logic root_lookup_fault, second_step_or_root_lookup, guest_lookup_fault;
  logic first_step_guest_lookup, root_interrupt_enabled;
  int fails = 0, cmp_count = 0;
  exc_kind_t kinds[8] = '{EXC_RESET, EXC_STEP, EXC_DBGINT, EXC_IMPR,
    EXC_NMI, EXC_MCHECK, EXC_MCHECK, EXC_INTR};
  logic [4:0] codes[8] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h18,
    5'h18, 5'h00};
  always #25 pclk = ~pclk;
  exc_source_model src (.req, .sys_reset_req, .nmi_in, .single_step_break,
    .debug_interrupt_request, .controller_break, .root_interrupt,
    .imprecise_load_data_break, .root_lookup_fault, .guest_lookup_fault,
    .second_step_or_root_lookup, .first_step_guest_lookup,
    .root_interrupt_enabled);
  exception_priority_encoder #(.NUM_VP(4)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sys_reset_req, .nmi_in, .debug_interrupt_request, .controller_break,
    .cur_vp, .single_step_break, .imprecise_load_data_break,
    .root_lookup_fault, .guest_lookup_fault, .second_step_or_root_lookup,
    .first_step_guest_lookup, .lookup_fault_cause, .root_interrupt,
    .root_interrupt_enabled, .exc_valid, .exc_kind, .exception_code_field,
    .core_reset);
  // One bus transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    `CHK("register", e, rd)
  endtask
  // Requests for one cycle, winner checked after that edge
  task automatic fire(input logic [9:0] v, input exc_kind_t k,
    input logic [4:0] c);
    req <= v;
    @(posedge pclk);
    req <= 0;
    @(negedge pclk);
    `CHK("valid", k != EXC_NONE, exc_valid)
    `CHK("core_reset", k == EXC_RESET, core_reset)
    if (k != EXC_NONE) begin
      `CHK("kind", k, exc_kind)
      `CHK("code", c, exception_code_field)
    end
    @(posedge pclk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdchk(`REG_LAST, 32'h0000_001f);
    rdchk(`REG_DEBUG, 32'h0000_0000);
    rdchk(`REG_CTRL, 32'h0000_007e);
    fire(10'h100, EXC_DBGINT, 5'h1f);
    fire(10'h200, EXC_NONE, 5'h1f);
    for (int i = 0; i < 8; i++) begin
      lookup_fault_cause <= 4'(i + 3);
      fire(10'h0ff & ~((10'h1 << i) - 10'h1), kinds[i], codes[i]);
    end
    rdchk(`REG_DEBUG, 32'h0000_0403);
    rdchk(`REG_STATUS, 32'h0000_0001);
    rdchk(`REG_ROOT_GRAIN, 32'h0000_0008);
    rdchk(`REG_GUEST_GRAIN, 32'h0000_0009);
    rdchk(`REG_LAST, 32'h0000_0000);
    apb(1, `REG_DEBUG, 32'hffff_ffff);
    rdchk(`REG_DEBUG, 32'h0000_0000);
    apb(0, 12'h020, 32'h0);
    `CHK("slverr", 1'b1, err)
    complete_run();
  end
endmodule
